// File: hw/bccf_charge_fsm.v
// Charge control logic of a single-cell linear charger: current mode selection,
// charge state machine, input and end-of-charge event flags.
// Assumes analog comparator results and safety timer expiries arrive synchronous to core_clk.
// Notes on behaviour
// - Rail sag over 200mV reduces charge current
// - Wall select and level high: programmed fast-charge current
// - Wall mode, level low: current divided by five
// - Bus mode: input limit 450 or 100mA
// - Precondition current: bus 45mA, wall one tenth
// - Connect event raises input interrupt when enabled
// - Disconnect event raises input interrupt when enabled
// - Input valid between lockout and overvoltage
// - Input status reads one, clears on read
// - Wall select state bit mirrors select input
// - Cycle starts precondition, moves to fast-charge
// - Precondition timer expiry goes to fault
// - Fast-charge until termination, then top-off
// - Total timeout in fast-charge: EOC, relax, restart
// - Top-off until current low, then EOC
// - Total timeout in top-off: restart on droop
// - EOC high impedance, restart on 205mV droop
// - Suspend on no battery, lockout, overvoltage
// - Manual suspend holds; clearing starts new cycle
// - EOC entry and exit interrupts when enabled
// - EOC flag; charger status clears on read
// - Two-bit charge state code always readable
`timescale 1ns/1ps
`include "bccf_consts.vh"
module bccf_charge_fsm #(
	parameter [`BCCF_RELAX_W-1:0] RELAX_CYCLES = `BCCF_RELAX_CYC // Relax delay in cycles
) (
	input  wire                    core_clk,               // Core clock, 10 MHz
	input  wire                    rst_n,                  // Async reset, active low
	input  wire                    wallSupplySelectIn,     // Wall select above threshold
	input  wire                    chargeLevelIn,          // Charge level input
	input  wire                    inputAboveUvlo,         // Charger input above lockout
	input  wire                    inputAboveOvp,          // Charger input above overvoltage
	input  wire                    batteryPresent,         // Battery detected
	input  wire                    batteryAbovePrecond,    // Cell above precondition threshold
	input  wire                    batteryAtTermination,   // Cell reached termination voltage
	input  wire                    chargeCurrentAtEoc,     // Current fell to end-of-charge level
	input  wire                    batteryBelowRecharge,   // Cell 205mV below termination
	input  wire                    systemRailSagged,       // System rail dropped over 200mV
	input  wire                    precondTimerExpired,    // Precondition timer expired
	input  wire                    totalTimerExpired,      // Total charge timer expired
	input  wire                    manualSuspend,          // Software suspend bit
	input  wire                    inputIrqEn,             // Input interrupt enable
	input  wire                    inputConnectIrqEn,      // Connect event enable
	input  wire                    inputDisconnectIrqEn,   // Disconnect event enable
	input  wire                    chargerIrqEn,           // Charger interrupt enable
	input  wire                    eocEntryIrqEn,          // EOC entry event enable
	input  wire                    eocExitIrqEn,           // EOC exit event enable
	input  wire                    inputIrqStatusRead,     // Read pulse of input status
	input  wire                    chargerIrqStatusRead,   // Read pulse of charger status
	output wire                    inputIrqStatus,         // Input interrupt status flag
	output wire                    chargerIrqStatus,       // Charger interrupt status flag
	output wire                    irqRequest,             // Either status flag pending
	output reg                     inputValidFlag,         // Valid input present
	output reg                     wallSelectState,        // Wall select state bit
	output reg                     eocStateFlag,           // In end-of-charge
	output reg  [1:0]              chargeStateCode,        // Two-bit charge state code
	output reg  [`BCCF_CUR_W-1:0]  chargeCurrentSel,       // Charge current selection
	output reg  [`BCCF_ILIM_W-1:0] inputCurrentLimitSel,   // Input current limit selection
	output reg                     currentReduce,          // Dynamic current reduction active
	output reg                     constantCurrentMode,    // Regulating current
	output reg                     constantVoltageMode,    // Regulating voltage
	output reg                     batteryHighZ,           // Charger off the battery
	output reg                     timeoutFault            // In time-out fault
);
	reg [`BCCF_ST_W-1:0]   state_q;
	reg [`BCCF_ST_W-1:0]   state_d;
	reg                    inputValidPrev_q;
	reg                    relaxPending_q;
	reg                    relaxPending_d;
	reg [`BCCF_RELAX_W-1:0] relaxCnt_q;
	reg [`BCCF_RELAX_W-1:0] relaxCnt_d;
	reg [1:0]              code_d;
	reg [`BCCF_CUR_W-1:0]  cur_d;
	reg [`BCCF_ILIM_W-1:0] ilim_d;

	wire inputValidNow;
	wire suspendCond;
	wire connectEvent;
	wire disconnectEvent;
	wire eocEnter;
	wire eocLeave;
	wire relaxDone;
	wire [`BCCF_NFLAG-1:0] flagSet;
	wire [`BCCF_NFLAG-1:0] flagRead;
	wire [`BCCF_NFLAG-1:0] flagOut;

	assign inputValidNow = inputAboveUvlo & ~inputAboveOvp;
	assign suspendCond = ~batteryPresent | ~inputValidNow | manualSuspend;

	// Edge of the present validity against its registered copy, so one event per change
	assign connectEvent = inputValidNow & ~inputValidPrev_q;
	assign disconnectEvent = ~inputValidNow & inputValidPrev_q;
	assign eocEnter = (state_d == `BCCF_ST_EOC) && (state_q != `BCCF_ST_EOC);
	assign eocLeave = (state_d != `BCCF_ST_EOC) && (state_q == `BCCF_ST_EOC);
	assign relaxDone = relaxPending_q && (relaxCnt_q >= RELAX_CYCLES - 1'b1);

	assign flagSet[`BCCF_FLAG_INPUT] = inputIrqEn & ((connectEvent & inputConnectIrqEn) |
		(disconnectEvent & inputDisconnectIrqEn));
	assign flagSet[`BCCF_FLAG_CHARGER] = chargerIrqEn & ((eocEnter & eocEntryIrqEn) |
		(eocLeave & eocExitIrqEn));
	assign flagRead[`BCCF_FLAG_INPUT] = inputIrqStatusRead;
	assign flagRead[`BCCF_FLAG_CHARGER] = chargerIrqStatusRead;

	genvar gi;
	generate
		for (gi = 0; gi < `BCCF_NFLAG; gi = gi + 1) begin : gFlag
			bccf_event_flag uFlag (
				.core_clk   (core_clk),
				.rst_n      (rst_n),
				.setEvent   (flagSet[gi]),
				.readStrobe (flagRead[gi]),
				.flag       (flagOut[gi])
			);
		end
	endgenerate

	assign inputIrqStatus = flagOut[`BCCF_FLAG_INPUT];
	assign chargerIrqStatus = flagOut[`BCCF_FLAG_CHARGER];
	assign irqRequest = |flagOut;

	// Next state
	always @* begin
		state_d = state_q;
		relaxPending_d = relaxPending_q;
		relaxCnt_d = relaxCnt_q;
		if (relaxPending_q)
			relaxCnt_d = relaxCnt_q + 1'b1;
		case (state_q)
			`BCCF_ST_SUSPEND: begin
				state_d = `BCCF_ST_PRECOND;
			end
			`BCCF_ST_PRECOND: begin
				if (batteryAbovePrecond)
					state_d = `BCCF_ST_FAST;
				else if (precondTimerExpired)
					state_d = `BCCF_ST_FAULT;
			end
			`BCCF_ST_FAST: begin
				if (batteryAtTermination)
					state_d = `BCCF_ST_TOPOFF;
				else if (totalTimerExpired) begin
					state_d = `BCCF_ST_EOC;
					relaxPending_d = 1'b1;
					relaxCnt_d = {`BCCF_RELAX_W{1'b0}};
				end
			end
			`BCCF_ST_TOPOFF: begin
				if (chargeCurrentAtEoc || totalTimerExpired)
					state_d = `BCCF_ST_EOC;
			end
			`BCCF_ST_EOC: begin
				if (relaxPending_q) begin
					if (relaxDone) begin
						state_d = `BCCF_ST_PRECOND;
						relaxPending_d = 1'b0;
					end
				end else if (batteryBelowRecharge)
					state_d = `BCCF_ST_PRECOND;
			end
			`BCCF_ST_FAULT: begin
				// Only a suspend condition leaves the fault
				state_d = `BCCF_ST_FAULT;
			end
			default: begin
				state_d = `BCCF_ST_SUSPEND;
			end
		endcase
		if (suspendCond) begin
			state_d = `BCCF_ST_SUSPEND;
			relaxPending_d = 1'b0;
		end
	end

	// Output decode of the next state, registered below
	always @* begin
		case (state_d)
			`BCCF_ST_PRECOND: code_d = `BCCF_CODE_PRECOND;
			`BCCF_ST_FAST:    code_d = `BCCF_CODE_CHARGING;
			`BCCF_ST_TOPOFF:  code_d = `BCCF_CODE_CHARGING;
			`BCCF_ST_EOC:     code_d = `BCCF_CODE_EOC;
			default:          code_d = `BCCF_CODE_IDLE;
		endcase
	end

	always @* begin
		if (wallSupplySelectIn)
			ilim_d = `BCCF_ILIM_WALL;
		else if (chargeLevelIn)
			ilim_d = `BCCF_ILIM_BUS_450;
		else
			ilim_d = `BCCF_ILIM_BUS_100;
		case (state_d)
			`BCCF_ST_PRECOND: begin
				if (wallSupplySelectIn)
					cur_d = `BCCF_CUR_PROG_TENTH;
				else
					cur_d = `BCCF_CUR_BUS_PRE_45;
			end
			`BCCF_ST_FAST, `BCCF_ST_TOPOFF: begin
				if (wallSupplySelectIn && chargeLevelIn)
					cur_d = `BCCF_CUR_PROG;
				else if (wallSupplySelectIn)
					cur_d = `BCCF_CUR_PROG_DIV5;
				else if (chargeLevelIn)
					cur_d = `BCCF_CUR_BUS_450;
				else
					cur_d = `BCCF_CUR_BUS_90;
			end
			default: begin
				cur_d = `BCCF_CUR_OFF;
			end
		endcase
	end

	always @(posedge core_clk or negedge rst_n) begin
		if (!rst_n) begin
			state_q <= `BCCF_ST_SUSPEND;
			relaxPending_q <= 1'b0;
			relaxCnt_q <= {`BCCF_RELAX_W{1'b0}};
			inputValidPrev_q <= 1'b0;
			inputValidFlag <= 1'b0;
			wallSelectState <= 1'b0;
			eocStateFlag <= 1'b0;
			chargeStateCode <= `BCCF_CODE_IDLE;
			chargeCurrentSel <= `BCCF_CUR_OFF;
			inputCurrentLimitSel <= `BCCF_ILIM_BUS_100;
			currentReduce <= 1'b0;
			constantCurrentMode <= 1'b0;
			constantVoltageMode <= 1'b0;
			batteryHighZ <= 1'b1;
			timeoutFault <= 1'b0;
		end else begin
			state_q <= state_d;
			relaxPending_q <= relaxPending_d;
			relaxCnt_q <= relaxCnt_d;
			inputValidPrev_q <= inputValidNow;
			inputValidFlag <= inputValidNow;
			wallSelectState <= wallSupplySelectIn;
			eocStateFlag <= (state_d == `BCCF_ST_EOC);
			chargeStateCode <= code_d;
			chargeCurrentSel <= cur_d;
			inputCurrentLimitSel <= ilim_d;
			// Reduction only matters while current flows into the cell
			currentReduce <= systemRailSagged && (cur_d != `BCCF_CUR_OFF);
			constantCurrentMode <= (state_d == `BCCF_ST_PRECOND) || (state_d == `BCCF_ST_FAST);
			constantVoltageMode <= (state_d == `BCCF_ST_TOPOFF);
			batteryHighZ <= (cur_d == `BCCF_CUR_OFF);
			timeoutFault <= (state_d == `BCCF_ST_FAULT);
		end
	end
endmodule // bccf_charge_fsm

// File: include/bccf_consts.vh
// Constants for the battery charge control state machine.
// Assumes inclusion by bare name from the state machine, checker and bench files.
`ifndef BCCF_CONSTS_VH
`define BCCF_CONSTS_VH

// Core clock rate in kHz (10 MHz)
`define BCCF_CLK_KHZ          32'd10000
// Relax delay after a total-timer expiry in fast-charge, in ms
`define BCCF_RELAX_MS         32'd32
`define BCCF_RELAX_W          19
// Same delay in core clock cycles, sized to the relax counter
`define BCCF_RELAX_CYC        19'h4E200

// Charge state machine encodings
`define BCCF_ST_W             3
`define BCCF_ST_SUSPEND       3'h0
`define BCCF_ST_PRECOND       3'h1
`define BCCF_ST_FAST          3'h2
`define BCCF_ST_TOPOFF        3'h3
`define BCCF_ST_EOC           3'h4
`define BCCF_ST_FAULT         3'h5

// Two-bit charge-state code, bit 0 first column, bit 1 second
`define BCCF_CODE_PRECOND     2'h3
`define BCCF_CODE_CHARGING    2'h1
`define BCCF_CODE_EOC         2'h2
`define BCCF_CODE_IDLE        2'h0

// Charge current selection
`define BCCF_CUR_W            3
`define BCCF_CUR_OFF          3'h0
`define BCCF_CUR_BUS_90       3'h1
`define BCCF_CUR_BUS_450      3'h2
`define BCCF_CUR_BUS_PRE_45   3'h3
`define BCCF_CUR_PROG         3'h4
`define BCCF_CUR_PROG_DIV5    3'h5
`define BCCF_CUR_PROG_TENTH   3'h6

// Input current limit selection
`define BCCF_ILIM_W           2
`define BCCF_ILIM_BUS_100     2'h0
`define BCCF_ILIM_BUS_450     2'h1
`define BCCF_ILIM_WALL        2'h2

// Flag slots
`define BCCF_NFLAG            2
`define BCCF_FLAG_INPUT       0
`define BCCF_FLAG_CHARGER     1

`endif

// File: hw/bccf_event_flag.v
// Sticky event flag that clears when its status is read.
// Assumes set and read strobes are one-cycle pulses on core_clk.
`timescale 1ns/1ps
module bccf_event_flag (
	input  wire core_clk,   // Core clock
	input  wire rst_n,      // Async reset, active low
	input  wire setEvent,   // Event pulse
	input  wire readStrobe, // Status read pulse, clears flag
	output wire flag        // Sticky flag level
);
	reg flag_q;
	reg flag_d;

	// A set in the read cycle survives, so no event is lost
	always @* begin
		flag_d = flag_q;
		if (readStrobe)
			flag_d = 1'b0;
		if (setEvent)
			flag_d = 1'b1;
	end

	always @(posedge core_clk or negedge rst_n) begin
		if (!rst_n)
			flag_q <= 1'b0;
		else
			flag_q <= flag_d;
	end

	assign flag = flag_q;
endmodule // bccf_event_flag

// File: sim/bccf_host_model.sv
// Host side model: software suspend bit and one-cycle status reads.
// Assumes the bench changes hostReq only at falling edges of core_clk.
`timescale 1ns/1ps
module bccf_host_model (
	input  wire       core_clk,             // Core clock
	input  wire [2:0] hostReq,              // Suspend, charger read, input read
	input  wire       inputIrqStatus,       // Input status flag
	input  wire       chargerIrqStatus,     // Charger status flag
	output wire       manualSuspend,        // Software suspend bit
	output wire       chargerIrqStatusRead, // Charger read pulse
	output wire       inputIrqStatusRead,   // Input read pulse
	output logic [1:0] readValue = 2'h0     // Flags returned by the last read
);
	assign {manualSuspend, chargerIrqStatusRead, inputIrqStatusRead} = hostReq;
	// The flag is taken at the read edge, before that edge clears it
	always @(posedge core_clk) begin
		if (inputIrqStatusRead | chargerIrqStatusRead)
			readValue <= {chargerIrqStatusRead & chargerIrqStatus, inputIrqStatusRead & inputIrqStatus};
	end
endmodule // bccf_host_model

// File: sim/bccf_charge_fsm_chk.sv
// Assertions on the ports of the charge control block, bound below.
// Assumes inputs change away from the rising edge of core_clk.
`timescale 1ns/1ps
`include "bccf_consts.vh"
module bccf_charge_fsm_chk #(
	parameter [`BCCF_RELAX_W-1:0] RELAX_CYCLES = `BCCF_RELAX_CYC // Relax delay in cycles
) (
	input wire       core_clk,             // Clock
	input wire       rst_n,                // Reset, active low
	input wire       batteryPresent,       // Suspend cause
	input wire       inputAboveUvlo,       // Suspend cause
	input wire       inputAboveOvp,        // Suspend cause
	input wire       manualSuspend,        // Suspend cause
	input wire       batteryAbovePrecond,  // Cell state
	input wire       precondTimerExpired,  // Precondition timer
	input wire       batteryAtTermination, // Cell state
	input wire       totalTimerExpired,    // Total timer
	input wire       chargeCurrentAtEoc,   // Current at end level
	input wire       inputIrqEn,           // Input enable
	input wire       inputConnectIrqEn,    // Connect enable
	input wire       inputDisconnectIrqEn, // Disconnect enable
	input wire       chargerIrqEn,         // Charger enable
	input wire       eocEntryIrqEn,        // Entry enable
	input wire       eocExitIrqEn,         // Exit enable
	input wire       inputIrqStatusRead,   // Read pulse
	input wire       chargerIrqStatusRead, // Read pulse
	input wire       inputIrqStatus,       // Input flag
	input wire       chargerIrqStatus,     // Charger flag
	input wire       inputValidFlag,       // Valid input
	input wire       eocStateFlag,         // In end-of-charge
	input wire       constantCurrentMode,  // Regulating current
	input wire       constantVoltageMode,  // Regulating voltage
	input wire       batteryHighZ,         // Off the battery
	input wire       timeoutFault,         // In fault
	input wire [1:0] chargeStateCode       // State code
);
	wire susp = !batteryPresent | !inputAboveUvlo | inputAboveOvp | manualSuspend;
	default clocking @(posedge core_clk); endclocking
	default disable iff (!rst_n);
	sequence s_pre; chargeStateCode == `BCCF_CODE_PRECOND && !susp; endsequence
	sequence s_fast; chargeStateCode == `BCCF_CODE_CHARGING && constantCurrentMode && !susp; endsequence
	property p_susp; susp |=> chargeStateCode == `BCCF_CODE_IDLE && batteryHighZ; endproperty
	a_susp: assert property (p_susp) else $error("suspend not entered");
	property p_start; chargeStateCode == `BCCF_CODE_IDLE && !timeoutFault && !susp
		|=> chargeStateCode == `BCCF_CODE_PRECOND; endproperty
	a_start: assert property (p_start) else $error("no new cycle");
	property p_prefast; s_pre ##0 batteryAbovePrecond |=> s_fast or chargeStateCode == `BCCF_CODE_CHARGING; endproperty
	a_prefast: assert property (p_prefast) else $error("no fast charge");
	property p_fault; s_pre ##0 (!batteryAbovePrecond && precondTimerExpired) |=> timeoutFault; endproperty
	a_fault: assert property (p_fault) else $error("no fault");
	property p_fasttop; s_fast ##0 batteryAtTermination |=> constantVoltageMode; endproperty
	a_fasttop: assert property (p_fasttop) else $error("no top-off");
	property p_fasteoc; s_fast ##0 (!batteryAtTermination && totalTimerExpired) |=> eocStateFlag; endproperty
	a_fasteoc: assert property (p_fasteoc) else $error("no timeout end");
	property p_topeoc; constantVoltageMode && !susp && (chargeCurrentAtEoc || totalTimerExpired)
		|=> eocStateFlag && batteryHighZ; endproperty
	a_topeoc: assert property (p_topeoc) else $error("no end of charge");
	property p_code; eocStateFlag == (chargeStateCode == `BCCF_CODE_EOC)
		&& (!timeoutFault || chargeStateCode == `BCCF_CODE_IDLE); endproperty
	a_code: assert property (p_code) else $error("state code");
	property p_valid; 1'b1 |=> inputValidFlag == $past(inputAboveUvlo && !inputAboveOvp); endproperty
	a_valid: assert property (p_valid) else $error("valid flag");
	property p_inirq; $changed(inputValidFlag) && (inputValidFlag ? $past(inputIrqEn && inputConnectIrqEn)
		: $past(inputIrqEn && inputDisconnectIrqEn)) |-> inputIrqStatus; endproperty
	a_inirq: assert property (p_inirq) else $error("input event lost");
	property p_chgirq; $changed(eocStateFlag) && $past(chargerIrqEn)
		&& (eocStateFlag ? $past(eocEntryIrqEn) : $past(eocExitIrqEn)) |-> chargerIrqStatus; endproperty
	a_chgirq: assert property (p_chgirq) else $error("charger event lost");
	property p_clear; inputIrqStatusRead || chargerIrqStatusRead |=> (!inputIrqStatus || $changed(inputValidFlag)
		|| !$past(inputIrqStatusRead)) && (!chargerIrqStatus || $changed(eocStateFlag) || !$past(chargerIrqStatusRead));
	endproperty
	a_clear: assert property (p_clear) else $error("flag not cleared");
endmodule // bccf_charge_fsm_chk
bind bccf_charge_fsm bccf_charge_fsm_chk #(.RELAX_CYCLES(RELAX_CYCLES)) i_chk (.*);

// File: sim/tb_top.sv
// Bench for the charge control block: directed state walk, then random mode traffic.
// Assumes the checker binds itself and the host model issues status reads.
`timescale 1ns/1ps
`include "bccf_consts.vh"
module tb_top;
	localparam [`BCCF_RELAX_W-1:0] RELAX = 19'h8;
	logic core_clk = 0, rst_n = 0, wallSupplySelectIn = 0, chargeLevelIn = 0, inputAboveUvlo = 1;
	logic inputAboveOvp = 0, batteryPresent = 1, batteryAbovePrecond = 0, batteryAtTermination = 0;
	logic chargeCurrentAtEoc = 0, batteryBelowRecharge = 0, systemRailSagged = 0, precondTimerExpired = 0;
	logic totalTimerExpired = 0, inputIrqEn = 1, inputConnectIrqEn = 1, inputDisconnectIrqEn = 1;
	logic chargerIrqEn = 1, eocEntryIrqEn = 1, eocExitIrqEn = 1;
	logic [2:0] hostReq = 3'h0;
	logic [31:0] seed = 32'h12E565E4;
	wire manualSuspend, inputIrqStatusRead, chargerIrqStatusRead, inputIrqStatus, chargerIrqStatus, irqRequest;
	wire inputValidFlag, wallSelectState, eocStateFlag, currentReduce, constantCurrentMode, constantVoltageMode;
	wire batteryHighZ, timeoutFault;
	wire [1:0] chargeStateCode, inputCurrentLimitSel, readValue;
	wire [2:0] chargeCurrentSel;
	int n_mismatch = 0;
	int samples_checked = 0;
	bccf_charge_fsm #(.RELAX_CYCLES(RELAX)) i_bccf_charge_fsm (.*);
	bccf_host_model i_bccf_host_model (.*);
	always #50 core_clk = ~core_clk;
	function automatic logic [31:0] lfsr(input logic [31:0] s);
		return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
	endfunction
	function automatic logic [2:0] expCur(input logic pre, wall, lvl);
		if (pre)
			return wall ? `BCCF_CUR_PROG_TENTH : `BCCF_CUR_BUS_PRE_45;
		return wall ? (lvl ? `BCCF_CUR_PROG : `BCCF_CUR_PROG_DIV5) : (lvl ? `BCCF_CUR_BUS_450 : `BCCF_CUR_BUS_90);
	endfunction
	task chk(input logic [7:0] got, exp);
		samples_checked++;
		if (got !== exp) begin
			n_mismatch++;
			$display("mismatch t=%0t got=%h exp=%h", $time, got, exp);
		end
	endtask
	task tick(input int n = 1);
		repeat (n) @(negedge core_clk);
	endtask
	task code(input logic [1:0] c);
		tick();
		chk(chargeStateCode, c);
	endtask
	task go(input logic [3:0] a, input logic [1:0] c);
		{batteryAbovePrecond, batteryAtTermination, chargeCurrentAtEoc, batteryBelowRecharge} = a;
		code(c);
	endtask
	// Reads leave one idle cycle so the strobe is never set and cleared at once
	task rd(input int which, input logic exp);
		hostReq[which] = 1'b1;
		tick();
		hostReq[which] = 1'b0;
		chk(readValue[which], exp);
		tick();
	endtask
	task report_and_stop;
		$display("checked %0d mismatches %0d", samples_checked, n_mismatch);
		if (n_mismatch == 0 && samples_checked > 0)
			$display("RESULT: PASS");
		else
			$display("RESULT: FAIL");
		$finish;
	endtask
	initial begin
		repeat (3) @(posedge core_clk);
		@(negedge core_clk) rst_n = 1'b1;
		code(`BCCF_CODE_PRECOND);
		rd(0, 1'b1);
		rd(0, 1'b0);
		go(4'b1000, `BCCF_CODE_CHARGING);
		go(4'b1100, `BCCF_CODE_CHARGING);
		chk(constantVoltageMode, 1'b1);
		go(4'b1110, `BCCF_CODE_EOC);
		chk({eocStateFlag, batteryHighZ}, 2'h3);
		chk(irqRequest, 1'b1);
		rd(1, 1'b1);
		go(4'b1100, `BCCF_CODE_EOC);
		go(4'b0001, `BCCF_CODE_PRECOND);
		rd(1, 1'b1);
		precondTimerExpired = 1'b1;
		code(`BCCF_CODE_IDLE);
		precondTimerExpired = 1'b0;
		code(`BCCF_CODE_IDLE);
		chk(timeoutFault, 1'b1);
		hostReq[2] = 1'b1;
		code(`BCCF_CODE_IDLE);
		hostReq[2] = 1'b0;
		code(`BCCF_CODE_PRECOND);
		go(4'b1000, `BCCF_CODE_CHARGING);
		totalTimerExpired = 1'b1;
		code(`BCCF_CODE_EOC);
		totalTimerExpired = 1'b0;
		go(4'b0000, `BCCF_CODE_EOC);
		tick(RELAX - 3);
		chk(chargeStateCode, `BCCF_CODE_EOC);
		tick();
		chk(chargeStateCode, `BCCF_CODE_EOC);
		tick();
		chk(chargeStateCode, `BCCF_CODE_PRECOND);
		go(4'b1000, `BCCF_CODE_CHARGING);
		go(4'b1100, `BCCF_CODE_CHARGING);
		totalTimerExpired = 1'b1;
		code(`BCCF_CODE_EOC);
		totalTimerExpired = 1'b0;
		tick(RELAX + 4);
		chk(chargeStateCode, `BCCF_CODE_EOC);
		go(4'b0001, `BCCF_CODE_PRECOND);
		// Entry and exit events of both timed-out cycles are still pending
		rd(1, 1'b1);
		for (int i = 0; i < 3; i++) begin
			go(4'b1000, `BCCF_CODE_CHARGING);
			{batteryPresent, inputAboveUvlo, inputAboveOvp} = 3'b110 ^ (3'b100 >> i);
			code(`BCCF_CODE_IDLE);
			rd(0, i > 0);
			{batteryPresent, inputAboveUvlo, inputAboveOvp} = 3'b110;
			code(`BCCF_CODE_PRECOND);
			rd(0, i > 0);
		end
		// Masked enables must swallow the events for good
		{inputIrqEn, chargerIrqEn, eocExitIrqEn, inputAboveUvlo} = 4'h0;
		code(`BCCF_CODE_IDLE);
		inputAboveUvlo = 1'b1;
		code(`BCCF_CODE_PRECOND);
		rd(0, 1'b0);
		go(4'b1000, `BCCF_CODE_CHARGING);
		go(4'b1100, `BCCF_CODE_CHARGING);
		go(4'b1110, `BCCF_CODE_EOC);
		rd(1, 1'b0);
		chargerIrqEn = 1'b1;
		go(4'b0001, `BCCF_CODE_PRECOND);
		rd(1, 1'b0);
		chk(irqRequest, 1'b0);
		{inputIrqEn, eocExitIrqEn} = 2'h3;
		for (int p = 1; p >= 0; p--) begin
			batteryAbovePrecond = !p;
			tick();
			repeat (100) begin
				seed = lfsr(seed);
				{wallSupplySelectIn, chargeLevelIn, systemRailSagged} = seed[2:0];
				tick();
				chk(chargeCurrentSel, expCur(p, wallSupplySelectIn, chargeLevelIn));
				chk(inputCurrentLimitSel, wallSupplySelectIn ? `BCCF_ILIM_WALL
					: chargeLevelIn ? `BCCF_ILIM_BUS_450 : `BCCF_ILIM_BUS_100);
				chk({currentReduce, wallSelectState}, {systemRailSagged, wallSupplySelectIn});
			end
		end
		report_and_stop();
	end
	// Directed and random parts take well under 1000 cycles
	initial begin
		repeat (3000) @(posedge core_clk);
		n_mismatch++;
		report_and_stop();
	end
endmodule // tb_top
